/* File: rtl/clc_map.svh */
`ifndef CLC_MAP_SVH
`define CLC_MAP_SVH

// ****************************************
// register byte addresses
// ****************************************
`define CLC_ADDR_LUT_F   8'h00
`define CLC_ADDR_LUT_G   8'h04
`define CLC_ADDR_LUT_H   8'h08
`define CLC_ADDR_CTRL    8'h0c
`define CLC_ADDR_CMAP    8'h10
`define CLC_ADDR_STATUS  8'h14

// ****************************************
// ctrl fields
// ****************************************
`define CLC_H0_FROM_F    0
`define CLC_H2_FROM_G    1
`define CLC_X_SEL_H      2
`define CLC_Y_SEL_H      3
`define CLC_XD_SRC       4
`define CLC_YD_SRC       6
`define CLC_X_CLK_INV    8
`define CLC_Y_CLK_INV    9
`define CLC_X_LATCH      10
`define CLC_Y_LATCH      11
`define CLC_X_EC_USED    12
`define CLC_Y_EC_USED    13
`define CLC_X_INIT_SET   14
`define CLC_Y_INIT_SET   15
`define CLC_X_SR_EN      16
`define CLC_Y_SR_EN      17
`define CLC_XQ_BYP       18
`define CLC_YQ_BYP       19
`define CLC_XQ_BYP_SRC   20
`define CLC_YQ_BYP_SRC   22
`define CLC_RAM_CLK_INV  24
`define CLC_CTRL_RST     32'h0003_0000

// ****************************************
// control input map fields
// ****************************************
`define CLC_MAP_H1       0
`define CLC_MAP_DIN      2
`define CLC_MAP_SR       4
`define CLC_MAP_EC       6
`define CLC_MAP_MEM_EN   8
`define CLC_MAP_MODE     9
`define CLC_CMAP_RST     32'h0000_00e4

// ****************************************
// bus responses
// ****************************************
`define CLC_RESP_OKAY    2'h0
`define CLC_RESP_SLVERR  2'h2

`endif

/* File: rtl/clc_pkg.sv */
package clc_pkg;

    typedef enum logic [1:0] {
        CLC_RAM_16X2,
        CLC_RAM_16X1,
        CLC_RAM_32X1
    } clc_ram_mode_e;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } clc_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } clc_axi_rsp_s;

    typedef struct packed {
        logic [15:0] lut_f;
        logic [15:0] lut_g;
        logic [7:0]  lut_h;
        logic [31:0] ctrl;
        logic [31:0] cmap;
        logic        q_x;
        logic        q_y;
        logic        ck_prev;
        logic        reinit;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } clc_state_s;

endpackage

/* File: rtl/clc_lookup.sv */
`timescale 1ns/1ps

module clc_lookup #(
    parameter int N = 4
) (
    input  wire logic [(1<<N)-1:0] table_bits,
    input  wire logic [N-1:0]      sel,
    output logic                   result
);

    // truth table indexed by the inputs
    assign result = table_bits[sel];

endmodule

/* File: rtl/clc_cell.sv */
`timescale 1ns/1ps
`include "clc_map.svh"

module clc_cell
    import clc_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire clc_axi_req_s axi_req,
    output clc_axi_rsp_s      axi_rsp,
    input  wire logic [3:0]   first_lookup_inputs,
    input  wire logic [3:0]   second_lookup_inputs,
    input  wire logic [3:0]   external_control_inputs,
    input  wire logic         cell_clock,
    input  wire logic         global_init_net,
    output logic              first_comb_output,
    output logic              second_comb_output,
    output logic              first_registered_output,
    output logic              second_registered_output
);

    // ****************************************
    // state
    // ****************************************
    localparam clc_state_s STATE_RST = '{
        ctrl:    `CLC_CTRL_RST,
        cmap:    `CLC_CMAP_RST,
        default: '0
    };

    clc_state_s s;
    clc_state_s s_nxt;

    // ****************************************
    // control mapping
    // ****************************************
    logic          first_external_input;
    logic          second_external_input;
    logic          zeroth_external_input;
    logic          cell_enable;
    logic          mem_en;
    clc_ram_mode_e ram_mode;

    assign first_external_input  = external_control_inputs[s.cmap[`CLC_MAP_H1 +: 2]];
    assign second_external_input = external_control_inputs[s.cmap[`CLC_MAP_DIN +: 2]];
    assign zeroth_external_input = external_control_inputs[s.cmap[`CLC_MAP_SR +: 2]];
    assign cell_enable           = external_control_inputs[s.cmap[`CLC_MAP_EC +: 2]];
    assign mem_en                = s.cmap[`CLC_MAP_MEM_EN];
    assign ram_mode              = clc_ram_mode_e'(s.cmap[`CLC_MAP_MODE +: 2]);

    // memory mode names for the same lines
    logic local_preset_clear;
    logic write_strobe;
    logic first_data_input;
    logic second_data_input;

    assign local_preset_clear = zeroth_external_input & ~mem_en;
    assign write_strobe       = zeroth_external_input & mem_en;
    assign first_data_input   = second_external_input;
    assign second_data_input  = first_external_input;

    // ****************************************
    // lookup tables
    // ****************************************
    logic       f_res;
    logic       g_res;
    logic       h_res;
    logic [2:0] h_in;

    clc_lookup #(.N(4)) u_lut_f (
        .table_bits (s.lut_f),
        .sel        (first_lookup_inputs),
        .result     (f_res)
    );

    clc_lookup #(.N(4)) u_lut_g (
        .table_bits (s.lut_g),
        .sel        (second_lookup_inputs),
        .result     (g_res)
    );

    assign h_in[0] = s.ctrl[`CLC_H0_FROM_F] ? f_res : zeroth_external_input;
    assign h_in[1] = first_external_input;
    assign h_in[2] = s.ctrl[`CLC_H2_FROM_G] ? g_res : second_external_input;

    clc_lookup #(.N(3)) u_lut_h (
        .table_bits (s.lut_h),
        .sel        (h_in),
        .result     (h_res)
    );

    assign first_comb_output  = s.ctrl[`CLC_X_SEL_H] ? h_res : f_res;
    assign second_comb_output = s.ctrl[`CLC_Y_SEL_H] ? h_res : g_res;

    // ****************************************
    // storage element inputs
    // ****************************************
    function automatic logic pick_d(
        input logic [1:0] src,
        input logic       f,
        input logic       g,
        input logic       h,
        input logic       din
    );
        logic r;
        case (src)
            2'h0:    r = f;
            2'h1:    r = g;
            2'h2:    r = h;
            default: r = din;
        endcase
        return r;
    endfunction

    function automatic logic next_q(
        input logic q,
        input logic d,
        input logic now,
        input logic prev,
        input logic latch,
        input logic ce
    );
        logic r;
        r = q;
        if (ce) begin
            if (latch) begin
                r = now ? q : d;
            end else if (now && !prev) begin
                r = d;
            end
        end
        return r;
    endfunction

    logic d_x;
    logic d_y;
    logic ck_x_now;
    logic ck_x_prev;
    logic ck_y_now;
    logic ck_y_prev;
    logic ce_x;
    logic ce_y;
    logic init_x;
    logic init_y;
    logic force_x;
    logic force_y;
    logic ram_rise;

    assign d_x = pick_d(s.ctrl[`CLC_XD_SRC +: 2], f_res, g_res, h_res, second_external_input);
    assign d_y = pick_d(s.ctrl[`CLC_YD_SRC +: 2], f_res, g_res, h_res, second_external_input);

    assign ck_x_now  = cell_clock ^ s.ctrl[`CLC_X_CLK_INV];
    assign ck_x_prev = s.ck_prev ^ s.ctrl[`CLC_X_CLK_INV];
    assign ck_y_now  = cell_clock ^ s.ctrl[`CLC_Y_CLK_INV];
    assign ck_y_prev = s.ck_prev ^ s.ctrl[`CLC_Y_CLK_INV];

    assign ce_x = ~s.ctrl[`CLC_X_EC_USED] | cell_enable;
    assign ce_y = ~s.ctrl[`CLC_Y_EC_USED] | cell_enable;

    assign init_x = s.ctrl[`CLC_X_INIT_SET];
    assign init_y = s.ctrl[`CLC_Y_INIT_SET];

    assign force_x = global_init_net | s.reinit | (s.ctrl[`CLC_X_SR_EN] & local_preset_clear);
    assign force_y = global_init_net | s.reinit | (s.ctrl[`CLC_Y_SR_EN] & local_preset_clear);

    assign ram_rise = (cell_clock ^ s.ctrl[`CLC_RAM_CLK_INV])
                    & ~(s.ck_prev ^ s.ctrl[`CLC_RAM_CLK_INV]);

    // ****************************************
    // registered outputs
    // ****************************************
    logic sq_x;
    logic sq_y;

    assign sq_x = force_x ? init_x : s.q_x;
    assign sq_y = force_y ? init_y : s.q_y;

    assign first_registered_output = s.ctrl[`CLC_XQ_BYP]
        ? external_control_inputs[s.ctrl[`CLC_XQ_BYP_SRC +: 2]] : sq_x;
    assign second_registered_output = s.ctrl[`CLC_YQ_BYP]
        ? external_control_inputs[s.ctrl[`CLC_YQ_BYP_SRC +: 2]] : sq_y;

    // ****************************************
    // bus handshakes
    // ****************************************
    assign axi_rsp.awready = ~s.aw_got & ~s.bvalid;
    assign axi_rsp.wready  = ~s.w_got & ~s.bvalid;
    assign axi_rsp.arready = ~s.rvalid;
    assign axi_rsp.bvalid  = s.bvalid;
    assign axi_rsp.bresp   = s.bresp;
    assign axi_rsp.rvalid  = s.rvalid;
    assign axi_rsp.rdata   = s.rdata;
    assign axi_rsp.rresp   = s.rresp;

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [31:0] m;
        s_nxt = s;
        m = 32'h0;
        s_nxt.reinit = 1'b0;
        if (axi_req.awvalid && axi_rsp.awready) begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            s_nxt.w_got  = 1'b1;
            s_nxt.w_data = axi_req.wdata;
            s_nxt.w_strb = axi_req.wstrb;
        end
        if (s.bvalid && axi_req.bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = `CLC_RESP_OKAY;
            s_nxt.reinit = 1'b1;
            case ({s.aw_addr[7:2], 2'b00})
                `CLC_ADDR_LUT_F: begin
                    m = merge({16'h0, s.lut_f}, s.w_data, s.w_strb);
                    s_nxt.lut_f = m[15:0];
                end
                `CLC_ADDR_LUT_G: begin
                    m = merge({16'h0, s.lut_g}, s.w_data, s.w_strb);
                    s_nxt.lut_g = m[15:0];
                end
                `CLC_ADDR_LUT_H: begin
                    m = merge({24'h0, s.lut_h}, s.w_data, s.w_strb);
                    s_nxt.lut_h = m[7:0];
                end
                `CLC_ADDR_CTRL: begin
                    s_nxt.ctrl = merge(s.ctrl, s.w_data, s.w_strb);
                end
                `CLC_ADDR_CMAP: begin
                    s_nxt.cmap = merge(s.cmap, s.w_data, s.w_strb);
                end
                default: begin
                    s_nxt.bresp  = `CLC_RESP_SLVERR;
                    s_nxt.reinit = 1'b0;
                end
            endcase
        end
        if (s.rvalid && axi_req.rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (axi_req.arvalid && axi_rsp.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = `CLC_RESP_OKAY;
            case ({axi_req.araddr[7:2], 2'b00})
                `CLC_ADDR_LUT_F:  s_nxt.rdata = {16'h0, s.lut_f};
                `CLC_ADDR_LUT_G:  s_nxt.rdata = {16'h0, s.lut_g};
                `CLC_ADDR_LUT_H:  s_nxt.rdata = {24'h0, s.lut_h};
                `CLC_ADDR_CTRL:   s_nxt.rdata = s.ctrl;
                `CLC_ADDR_CMAP:   s_nxt.rdata = s.cmap;
                `CLC_ADDR_STATUS: begin
                    s_nxt.rdata = {26'h0, second_comb_output, first_comb_output,
                                   second_registered_output, first_registered_output,
                                   s.q_y, s.q_x};
                end
                default: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rresp = `CLC_RESP_SLVERR;
                end
            endcase
        end
        // memory write, edge-triggered on the cell clock
        if (mem_en && write_strobe && ram_rise) begin
            case (ram_mode)
                CLC_RAM_16X2: begin
                    s_nxt.lut_f[first_lookup_inputs]  = first_data_input;
                    s_nxt.lut_g[second_lookup_inputs] = second_data_input;
                end
                CLC_RAM_16X1: begin
                    s_nxt.lut_f[first_lookup_inputs] = first_data_input;
                end
                CLC_RAM_32X1: begin
                    if (second_data_input) begin
                        s_nxt.lut_g[second_lookup_inputs] = first_data_input;
                    end else begin
                        s_nxt.lut_f[first_lookup_inputs] = first_data_input;
                    end
                end
                default: begin
                    s_nxt.lut_f = s.lut_f;
                end
            endcase
        end
        // storage elements run apart from the tables
        s_nxt.ck_prev = cell_clock;
        s_nxt.q_x = force_x ? init_x
                  : next_q(s.q_x, d_x, ck_x_now, ck_x_prev, s.ctrl[`CLC_X_LATCH], ce_x);
        s_nxt.q_y = force_y ? init_y
                  : next_q(s.q_y, d_y, ck_y_now, ck_y_prev, s.ctrl[`CLC_Y_LATCH], ce_y);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= STATE_RST;
        end else begin
            s <= s_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_flop_capture: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!s.ctrl[`CLC_X_LATCH] && ck_x_now && !ck_x_prev && ce_x && !force_x)
        |=> s.q_x == $past(d_x)
    ) else $error("x element missed its active edge");

    chk_enable_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s.ctrl[`CLC_X_EC_USED] && !cell_enable && !force_x) |=> $stable(s.q_x)
    ) else $error("x element changed with enable low");

    chk_latch_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s.ctrl[`CLC_X_LATCH] && ck_x_now && !force_x) |=> $stable(s.q_x)
    ) else $error("x latch changed while closed");

    chk_sr_force: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (force_x && !s.ctrl[`CLC_XQ_BYP])
        |-> first_registered_output == init_x ##1 s.q_x == $past(init_x)
    ) else $error("x output not forced to init value");

    chk_global_init: assert property (
        @(posedge aclk) disable iff (!aresetn)
        global_init_net |=> (s.q_x == $past(init_x)) && (s.q_y == $past(init_y))
    ) else $error("global init did not force both elements");

    chk_comb_path: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !s.ctrl[`CLC_Y_SEL_H] |-> second_comb_output == s.lut_g[second_lookup_inputs]
    ) else $error("second combinational output not from table");

    chk_ram_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (mem_en && ram_mode == CLC_RAM_16X1 && write_strobe && ram_rise)
        |=> s.lut_f[$past(first_lookup_inputs)] == $past(first_data_input)
    ) else $error("memory write not stored");

    chk_write_resp: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s.aw_got && s.w_got && ({s.aw_addr[7:2], 2'b00} <= `CLC_ADDR_CMAP))
        |=> s.bvalid ##1 (s.q_y == $past(init_y))
    ) else $error("write response or reinit missing");

    chk_ram_idle: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!mem_en && !(s.aw_got && s.w_got)) |=> $stable(s.lut_g)
    ) else $error("table changed outside memory mode");

endmodule

/* File: verification/clc_far_logic.sv */
`timescale 1ns/1ps

// ****************************************
// routing-side drive of the cell inputs
// ****************************************
module clc_far_logic
    import clc_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       rnd_en,
    input  wire logic [3:0] f_set,
    input  wire logic [3:0] g_set,
    input  wire logic [3:0] c_set,
    input  wire logic       ck_set,
    input  wire logic       gi_set,
    output logic [3:0]      f_drv,
    output logic [3:0]      g_drv,
    output logic [3:0]      c_drv,
    output logic            ck_drv,
    output logic            gi_drv
);
    int seed = 87;

    initial begin
        f_drv = 4'h0;
        g_drv = 4'h0;
        c_drv = 4'h0;
        ck_drv = 1'b0;
        gi_drv = 1'b0;
    end

    // user logic settles on the bus clock, like any routed net
    always @(posedge aclk) begin
        ck_drv <= ck_set;
        gi_drv <= gi_set;
        if (rnd_en) begin
            f_drv <= 4'($random(seed));
            g_drv <= 4'($random(seed));
            c_drv <= 4'($random(seed));
        end else begin
            f_drv <= f_set;
            g_drv <= g_set;
            c_drv <= c_set;
        end
    end
endmodule

/* File: verification/test_configurable_logic_cell.sv */
`timescale 1ns/1ps
`include "clc_map.svh"

module test_configurable_logic_cell
    import clc_pkg::*;
;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    clc_axi_req_s axi_req = '0;
    clc_axi_rsp_s axi_rsp;
    logic         rnd_en = 1'b0;
    logic [3:0]   c_set = 4'h0;
    logic [3:0]   f_set = 4'h0;
    logic [3:0]   g_set = 4'h0;
    logic         ck_set = 1'b0;
    logic         gi_set = 1'b0;
    logic [3:0]   f_drv;
    logic [3:0]   g_drv;
    logic [3:0]   c_drv;
    logic         ck_drv;
    logic         gi_drv;
    logic         x_comb;
    logic         y_comb;
    logic         x_reg;
    logic         y_reg;
    int           seed = 87;
    int           miscompares = 0;
    int           compares = 0;
    logic [15:0]  tf;
    logic [15:0]  tg;
    logic [31:0]  th;
    logic [31:0]  ct;
    logic [31:0]  cm;
    logic [31:0]  rd;
    logic [1:0]   rr;
    logic [3:0]   c;

    always #10 aclk = ~aclk;

    clc_far_logic far (.aclk(aclk), .rnd_en(rnd_en), .f_set(f_set), .g_set(g_set), .c_set(c_set),
        .ck_set(ck_set), .gi_set(gi_set), .f_drv(f_drv), .g_drv(g_drv), .c_drv(c_drv),
        .ck_drv(ck_drv), .gi_drv(gi_drv));

    clc_cell dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .first_lookup_inputs(f_drv), .second_lookup_inputs(g_drv), .external_control_inputs(c_drv),
        .cell_clock(ck_drv), .global_init_net(gi_drv), .first_comb_output(x_comb),
        .second_comb_output(y_comb), .first_registered_output(x_reg), .second_registered_output(y_reg));

    // ****************************************
    // checks and expectations
    // ****************************************
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_pin(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [1:0] comb_exp(input logic [15:0] a, input logic [15:0] b, input logic [7:0] h,
        input logic [31:0] k, input logic [31:0] m, input logic [3:0] f, input logic [3:0] g, input logic [3:0] e);
        logic fo;
        logic go;
        logic ho;
        fo = a[f];
        go = b[g];
        ho = h[{k[1] ? go : e[m[3:2]], e[m[1:0]], k[0] ? fo : e[m[5:4]]}];
        return {k[3] ? ho : go, k[2] ? ho : fo};
    endfunction

    // ****************************************
    // bus and cell drivers
    // ****************************************
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw;
        logic w;
        logic done;
        aw = 1'b1;
        w = 1'b1;
        done = 1'b0;
        @(posedge aclk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (aw && axi_rsp.awready) begin
                aw = 1'b0;
                axi_req.awvalid <= 1'b0;
            end
            if (w && axi_rsp.wready) begin
                w = 1'b0;
                axi_req.wvalid <= 1'b0;
            end
            if (axi_rsp.bvalid) begin
                done = 1'b1;
                resp = axi_rsp.bresp;
                axi_req.bready <= 1'b0;
            end
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar;
        logic done;
        ar = 1'b1;
        done = 1'b0;
        @(posedge aclk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (ar && axi_rsp.arready) begin
                ar = 1'b0;
                axi_req.arvalid <= 1'b0;
            end
            if (axi_rsp.rvalid) begin
                done = 1'b1;
                d = axi_rsp.rdata;
                resp = axi_rsp.rresp;
                axi_req.rready <= 1'b0;
            end
        end
    endtask

    task automatic step(input logic [3:0] e, input logic ck, input logic gi, input logic [1:0] exp);
        @(posedge aclk);
        c_set <= e;
        ck_set <= ck;
        gi_set <= gi;
        repeat (3) @(posedge aclk);
        #1;
        check_pin({y_reg, x_reg}, exp);
    endtask

    task automatic complete_run;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`CLC_ADDR_CTRL, rd, rr);
        check_reg(rd, `CLC_CTRL_RST);
        axi_read(`CLC_ADDR_CMAP, rd, rr);
        check_reg(rd, `CLC_CMAP_RST);
        axi_read(`CLC_ADDR_STATUS, rd, rr);
        check_reg(rd, 32'h0000_0000);
        axi_read(8'h18, rd, rr);
        check_reg({rr, rd[29:0]}, {`CLC_RESP_SLVERR, 30'h0});
        axi_write(8'h18, 32'hffff_ffff, rr);
        check_reg({30'h0, rr}, {30'h0, `CLC_RESP_SLVERR});
        @(posedge aclk);
        rnd_en <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            tf = 16'($random(seed));
            tg = 16'($random(seed));
            th = $random(seed);
            ct = {28'h0, 4'(i)};
            cm = {24'h0, 8'($random(seed))};
            axi_write(`CLC_ADDR_LUT_F, {16'h0, tf}, rr);
            axi_write(`CLC_ADDR_LUT_G, {16'h0, tg}, rr);
            axi_write(`CLC_ADDR_LUT_H, th, rr);
            axi_write(`CLC_ADDR_CTRL, ct, rr);
            axi_write(`CLC_ADDR_CMAP, cm, rr);
            axi_read(`CLC_ADDR_LUT_H, rd, rr);
            check_reg(rd, {24'h0, th[7:0]});
            repeat (16) begin
                @(negedge aclk);
                check_pin({y_comb, x_comb}, comb_exp(tf, tg, th[7:0], ct, cm, f_drv, g_drv, c_drv));
            end
        end
        @(posedge aclk);
        rnd_en <= 1'b0;
        // direct input on c1, preset/clear on c2, enable on c3
        axi_write(`CLC_ADDR_CMAP, 32'h0000_00e4, rr);
        axi_write(`CLC_ADDR_CTRL, 32'h0003_02f0, rr);
        step(4'b0000, 1'b0, 1'b0, 2'b00);
        step(4'b0010, 1'b1, 1'b0, 2'b01);
        step(4'b0010, 1'b0, 1'b0, 2'b11);
        step(4'b0000, 1'b1, 1'b0, 2'b10);
        axi_write(`CLC_ADDR_CTRL, 32'h0003_32f0, rr);
        step(4'b0010, 1'b0, 1'b0, 2'b00);
        step(4'b0010, 1'b1, 1'b0, 2'b00);
        step(4'b1010, 1'b0, 1'b0, 2'b10);
        step(4'b0110, 1'b0, 1'b0, 2'b00);
        axi_write(`CLC_ADDR_CTRL, 32'h0003_72f0, rr);
        step(4'b0100, 1'b0, 1'b0, 2'b01);
        step(4'b1000, 1'b1, 1'b0, 2'b00);
        step(4'b0000, 1'b1, 1'b1, 2'b01);
        axi_write(`CLC_ADDR_CTRL, 32'h0000_02f0, rr);
        step(4'b0110, 1'b0, 1'b0, 2'b10);
        axi_write(`CLC_ADDR_CTRL, 32'h0000_04f0, rr);
        step(4'b0010, 1'b1, 1'b0, 2'b11);
        step(4'b0000, 1'b1, 1'b0, 2'b11);
        step(4'b0000, 1'b0, 1'b0, 2'b10);
        for (int k = 0; k < 4; k++) begin
            axi_write(`CLC_ADDR_CTRL, 32'h000c_0000 | (k << 20) | ((3 - k) << 22), rr);
            c = 4'($random(seed));
            step(c, 1'b0, 1'b0, {c[3 - k], c[k]});
        end
        // tables as memory: strobe on c2, data on c1, upper address on c0
        axi_write(`CLC_ADDR_CTRL, 32'h0000_0000, rr);
        axi_write(`CLC_ADDR_LUT_F, 32'h0000_0000, rr);
        axi_write(`CLC_ADDR_CMAP, 32'h0000_03e4, rr);
        f_set <= 4'h5;
        step(4'b0110, 1'b1, 1'b0, 2'b00);
        step(4'b0000, 1'b0, 1'b0, 2'b00);
        step(4'b0000, 1'b1, 1'b0, 2'b11);
        axi_read(`CLC_ADDR_LUT_F, rd, rr);
        check_reg(rd, 32'h0000_0020);
        axi_write(`CLC_ADDR_CMAP, 32'h0000_05e4, rr);
        g_set <= 4'h3;
        step(4'b0111, 1'b0, 1'b0, 2'b00);
        step(4'b0111, 1'b1, 1'b0, 2'b11);
        axi_read(`CLC_ADDR_LUT_G, rd, rr);
        check_reg(rd, {16'h0, tg | 16'h0008});
        complete_run();
    end
endmodule
